// [rtl/uirq_pkg.sv]
// Package: register map, field layout and timing constants for the user interrupt helper
package uirq_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [11:0] UIRQ_OFS_REQUEST = 12'h0094;
  localparam logic [11:0] UIRQ_OFS_MASK = 12'h0098;
  localparam logic [11:0] UIRQ_OFS_PENDING = 12'h009c;
  localparam logic [11:0] UIRQ_OFS_SRST = 12'h00a0;
  localparam logic [11:0] UIRQ_OFS_MSG = 12'h00a4;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int UIRQ_FUNC_LSB = 12;
  localparam int UIRQ_FUNC_W = 8;
  localparam int UIRQ_VEC_LSB = 4;
  localparam int UIRQ_VEC_W = 5;
  localparam int UIRQ_TRIG_BIT = 0;
  localparam int UIRQ_SRST_BIT = 0;

  // ----------------------------------------
  // Reset values and timing
  // ----------------------------------------
  localparam logic [31:0] UIRQ_RST_WORD = 32'h0000_0000;
  localparam int UIRQ_SRST_CYCLES = 100;
  localparam int UIRQ_MSG_DEPTH = 16;

  // Register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [11:0] addr;
    logic [31:0] wdata;
  } uirq_reg_req_t;

  // Request toward the engine
  typedef struct packed {
    logic valid;
    logic [7:0] func;
    logic [4:0] vec;
  } uirq_irq_req_t;

  typedef enum logic [1:0] {
    UIRQ_IDLE = 2'b00,
    UIRQ_WAIT_ACK = 2'b01
  } uirq_state_t;

endpackage

// [rtl/uirq_msg_fifo.sv]
// Message word FIFO that software drains by reading a register
`timescale 1ns/1ps
module uirq_msg_fifo
  import uirq_pkg::*;
#(
  parameter int WIDTH = 32,
  parameter int DEPTH = UIRQ_MSG_DEPTH
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic push,
  input wire logic [WIDTH-1:0] push_data,
  input wire logic pop,
  output logic [WIDTH-1:0] head,
  output logic empty,
  output logic full
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;

  wire do_push = push && (!full || pop);
  wire do_pop = pop && !empty;

  assign head = mem[rd_ptr];
  assign empty = (count == '0);
  assign full = (count == (AW+1)'(DEPTH));

  // Storage
  always_ff @(posedge clk) begin
    if (do_push) begin
      mem[wr_ptr] <= push_data;
    end
  end

  // Pointers and occupancy
  always_ff @(posedge clk) begin
    if (srst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (do_push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (do_pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end

endmodule // uirq_msg_fifo

// [rtl/uirq_regs.sv]
// Register bank: user interrupt trigger and aggregation, engine soft reset, message pop
// Behaviour
// - Function number field, bits 19:12, to engine
// - Vector field, bits 8:4, to engine
// - Trigger bit starts request, clears on ack
// - One write sets function, vector, trigger together while idle
// - Mask AND pending raises an interrupt request
// - Reading pending returns it and clears it
// - Both sources drive the engine interrupt input
// - Mask and pending: 32 bits, writable, reset zero
// - Soft reset low 100 cycles on write
// - Soft reset bit self-clears after 100 cycles
// - Received message words enter the FIFO unless it is full
// - Message register read pops oldest word
`timescale 1ns/1ps
module uirq_regs
  import uirq_pkg::*;
#(
  parameter int MSG_DEPTH = UIRQ_MSG_DEPTH,
  parameter int SRST_CYCLES = UIRQ_SRST_CYCLES
) (
  input wire logic clk,
  input wire logic srst,
  input wire uirq_reg_req_t reg_req,
  output logic [31:0] reg_rdata,
  output logic reg_rvalid,
  output uirq_irq_req_t irq_out,
  input wire logic irq_ack,
  output logic engine_soft_reset_n,
  input wire logic msg_valid,
  input wire logic [31:0] received_message_word,
  output logic msg_ready
);

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  wire sel_req = (reg_req.addr == UIRQ_OFS_REQUEST);
  wire sel_mask = (reg_req.addr == UIRQ_OFS_MASK);
  wire sel_pend = (reg_req.addr == UIRQ_OFS_PENDING);
  wire sel_srst = (reg_req.addr == UIRQ_OFS_SRST);
  wire sel_msg = (reg_req.addr == UIRQ_OFS_MSG);

  wire wr_req = reg_req.wr && sel_req;
  wire wr_mask = reg_req.wr && sel_mask;
  wire wr_pend = reg_req.wr && sel_pend;
  wire wr_srst = reg_req.wr && sel_srst;
  wire rd_pend = reg_req.rd && sel_pend;
  wire rd_msg = reg_req.rd && sel_msg;

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  logic [UIRQ_FUNC_W-1:0] irq_func;
  logic [UIRQ_VEC_W-1:0] irq_vec;
  logic irq_trig;
  logic [31:0] agg_mask;
  logic [31:0] agg_pend;
  logic srst_bit;
  logic [6:0] srst_cnt;
  uirq_state_t state;
  uirq_state_t next_state;

  // Write data fields, all taken from the same word
  wire [UIRQ_FUNC_W-1:0] wr_func = reg_req.wdata[UIRQ_FUNC_LSB +: UIRQ_FUNC_W];
  wire [UIRQ_VEC_W-1:0] wr_vec = reg_req.wdata[UIRQ_VEC_LSB +: UIRQ_VEC_W];
  wire wr_trig = reg_req.wdata[UIRQ_TRIG_BIT];

  // Aggregation hit
  wire agg_hit = |(agg_mask & agg_pend);

  // Any source wants an interrupt; a trigger write counts in its own cycle
  wire irq_want = irq_trig || (wr_req && wr_trig) || agg_hit;

  // Handshake sequencing
  wire ack_seen = (state == UIRQ_WAIT_ACK) && irq_ack;
  always_comb begin
    next_state = state;
    unique case (state)
      UIRQ_IDLE: begin
        if (irq_want) begin
          next_state = UIRQ_WAIT_ACK;
        end
      end
      UIRQ_WAIT_ACK: begin
        if (irq_ack) begin
          next_state = UIRQ_IDLE;
        end
      end
      default: begin
        next_state = UIRQ_IDLE;
      end
    endcase
  end

  // Function and vector fields; frozen while a request is out
  always_ff @(posedge clk) begin
    if (srst) begin
      irq_func <= '0;
      irq_vec <= '0;
    end else if (wr_req && state == UIRQ_IDLE) begin
      irq_func <= wr_func;
      irq_vec <= wr_vec;
    end
  end

  // Trigger bit: set by write, cleared by ack; set wins
  always_ff @(posedge clk) begin
    if (srst) begin
      irq_trig <= 1'b0;
    end else if (wr_req && wr_trig) begin
      irq_trig <= 1'b1;
    end else if (ack_seen) begin
      irq_trig <= 1'b0;
    end
  end

  // Aggregation mask
  always_ff @(posedge clk) begin
    if (srst) begin
      agg_mask <= UIRQ_RST_WORD;
    end else if (wr_mask) begin
      agg_mask <= reg_req.wdata;
    end
  end

  // Pending bits: write loads, read clears; write wins
  always_ff @(posedge clk) begin
    if (srst) begin
      agg_pend <= UIRQ_RST_WORD;
    end else if (wr_pend) begin
      agg_pend <= reg_req.wdata;
    end else if (rd_pend) begin
      agg_pend <= UIRQ_RST_WORD;
    end
  end

  // Request state and output to the engine
  always_ff @(posedge clk) begin
    if (srst) begin
      state <= UIRQ_IDLE;
      irq_out <= '0;
    end else begin
      state <= next_state;
      irq_out.valid <= (next_state == UIRQ_WAIT_ACK);
      if (state == UIRQ_IDLE) begin
        irq_out.func <= (wr_req) ? wr_func : irq_func;
        irq_out.vec <= (wr_req) ? wr_vec : irq_vec;
      end
    end
  end

  // ----------------------------------------
  // Soft reset timer
  // ----------------------------------------
  wire srst_done = srst_bit && (srst_cnt == 7'(SRST_CYCLES - 1));
  always_ff @(posedge clk) begin
    if (srst) begin
      srst_bit <= 1'b0;
      srst_cnt <= '0;
      engine_soft_reset_n <= 1'b1;
    end else if (!srst_bit && wr_srst && reg_req.wdata[UIRQ_SRST_BIT]) begin
      srst_bit <= 1'b1;
      srst_cnt <= '0;
      engine_soft_reset_n <= 1'b0;
    end else if (srst_done) begin
      srst_bit <= 1'b0;
      engine_soft_reset_n <= 1'b1;
    end else if (srst_bit) begin
      srst_cnt <= srst_cnt + 7'd1;
    end
  end

  // ----------------------------------------
  // Message FIFO
  // ----------------------------------------
  logic [31:0] msg_head;
  logic msg_empty;
  logic msg_full;

  uirq_msg_fifo #(
    .WIDTH(32),
    .DEPTH(MSG_DEPTH)
  ) u_msg_fifo (
    .clk(clk),
    .srst(srst),
    .push(msg_valid && !msg_full),
    .push_data(received_message_word),
    .pop(rd_msg),
    .head(msg_head),
    .empty(msg_empty),
    .full(msg_full)
  );

  // Back-pressure toward the engine
  always_ff @(posedge clk) begin
    if (srst) begin
      msg_ready <= 1'b0;
    end else begin
      msg_ready <= !msg_full && !(msg_valid && msg_ready);
    end
  end

  // ----------------------------------------
  // Read data mux
  // ----------------------------------------
  wire [31:0] rd_req_word = {12'h000, irq_func, 3'b000, irq_vec, 3'b000, irq_trig};
  wire [31:0] rd_srst_word = {31'h0000_0000, srst_bit};
  wire [31:0] rd_msg_word = msg_empty ? 32'h0000_0000 : msg_head;
  wire [31:0] rd_word = sel_req ? rd_req_word :
                        sel_mask ? agg_mask :
                        sel_pend ? agg_pend :
                        sel_srst ? rd_srst_word :
                        sel_msg ? rd_msg_word : 32'h0000_0000;

  always_ff @(posedge clk) begin
    if (srst) begin
      reg_rdata <= '0;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_req.rd;
      reg_rdata <= reg_req.rd ? rd_word : reg_rdata;
    end
  end

endmodule // uirq_regs

// [test/uirq_regs_chk.sv]
// Checker: timing relations at the register bank ports
`timescale 1ns/1ps
module uirq_regs_chk
  import uirq_pkg::*;
#(
  parameter int SRST_CYCLES = UIRQ_SRST_CYCLES
) (
  input wire logic clk,
  input wire logic srst,
  input wire uirq_reg_req_t reg_req,
  input wire logic [31:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire uirq_irq_req_t irq_out,
  input wire logic irq_ack,
  input wire logic engine_soft_reset_n,
  input wire logic msg_valid,
  input wire logic [31:0] received_message_word,
  input wire logic msg_ready
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  logic [7:0] low_cnt;
  // Request and soft reset write decode
  wire req_wr = reg_req.wr && reg_req.addr == UIRQ_OFS_REQUEST;
  wire srst_wr = reg_req.wr && reg_req.addr == UIRQ_OFS_SRST && reg_req.wdata[0];
  wire mapped = reg_req.addr inside {UIRQ_OFS_REQUEST, UIRQ_OFS_MASK, UIRQ_OFS_PENDING, UIRQ_OFS_SRST, UIRQ_OFS_MSG};
  // Length of the soft reset pulse
  always_ff @(posedge clk) begin
    if (srst || engine_soft_reset_n) low_cnt <= 8'h00;
    else low_cnt <= low_cnt + 8'h01;
  end
  chk_read_answer: assert property (reg_req.rd |=> reg_rvalid)
    else $error("read got no answer");
  chk_answer_cause: assert property (reg_rvalid |-> $past(reg_req.rd))
    else $error("answer without read");
  chk_unmapped_zero: assert property (reg_req.rd && !mapped |=> reg_rdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  chk_trig_fields: assert property (req_wr && reg_req.wdata[0] && !irq_out.valid |=> irq_out.valid
    && irq_out.func == $past(reg_req.wdata[19:12]) && irq_out.vec == $past(reg_req.wdata[8:4]))
    else $error("trigger write gave wrong request");
  chk_hold_req: assert property (irq_out.valid && !irq_ack |=> irq_out.valid
    && $stable(irq_out.func) && $stable(irq_out.vec))
    else $error("request changed before ack");
  chk_ack_drop: assert property (irq_out.valid && irq_ack && !req_wr |=> !irq_out.valid)
    else $error("request held after ack");
  chk_srst_start: assert property (srst_wr && engine_soft_reset_n |=> !engine_soft_reset_n)
    else $error("soft reset not started");
  chk_srst_len: assert property ($rose(engine_soft_reset_n) |-> low_cnt == SRST_CYCLES)
    else $error("soft reset length wrong");
  chk_ready_gap: assert property (msg_valid && msg_ready |=> !msg_ready)
    else $error("ready not dropped after word");
endmodule // uirq_regs_chk

// [test/uirq_engine_model.sv]
// Engine model: acknowledges interrupt requests and delivers message words
`timescale 1ns/1ps
module uirq_engine_model
  import uirq_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire uirq_irq_req_t irq_out,
  input wire logic [3:0] ack_wait,
  input wire logic send,
  input wire logic [31:0] send_word,
  input wire logic msg_ready,
  output logic irq_ack,
  output logic msg_valid,
  output logic [31:0] received_message_word
);
  logic [3:0] wait_cnt;
  logic pend;
  logic [31:0] held;
  // Acknowledge after a programmable wait
  always_ff @(posedge clk) begin
    if (srst) begin
      irq_ack <= 1'b0;
      wait_cnt <= 4'h0;
    end else begin
      irq_ack <= irq_out.valid && !irq_ack && wait_cnt >= ack_wait;
      wait_cnt <= (irq_out.valid && !irq_ack && wait_cnt < ack_wait) ? wait_cnt + 4'h1 : 4'h0;
    end
  end
  // One word at a time, only offered while ready; data inverted when idle
  always_ff @(posedge clk) begin
    if (srst) begin
      pend <= 1'b0;
      msg_valid <= 1'b0;
      held <= '0;
      received_message_word <= '0;
    end else if (send) begin
      pend <= 1'b1;
      held <= send_word;
    end else if (pend && msg_ready && !msg_valid) begin
      pend <= 1'b0;
      msg_valid <= 1'b1;
      received_message_word <= held;
    end else if (msg_valid) begin
      msg_valid <= 1'b0;
      received_message_word <= ~received_message_word;
    end
  end
endmodule // uirq_engine_model

// [test/uirq_regs_tb.sv]
// Testbench: register accesses against the user interrupt helper
`timescale 1ns/1ps
module uirq_regs_tb;
  import uirq_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  uirq_reg_req_t req = '0;
  uirq_irq_req_t irq;
  logic rvalid, ack, n_rst, mvalid, mready;
  logic send = 1'b0;
  logic [31:0] rdata, mword;
  logic [31:0] sword = '0;
  logic [3:0] ack_wait = 4'h0;
  logic [11:0] offs [6] = '{12'h00a8, UIRQ_OFS_REQUEST, UIRQ_OFS_MASK, UIRQ_OFS_PENDING, UIRQ_OFS_SRST, UIRQ_OFS_MSG};
  int miscompares = 0;
  int check_count = 0;
  int i;
  always #25 clk = ~clk;
  uirq_regs DUT (.clk(clk), .srst(srst), .reg_req(req), .reg_rdata(rdata), .reg_rvalid(rvalid), .irq_out(irq),
    .irq_ack(ack), .engine_soft_reset_n(n_rst), .msg_valid(mvalid), .received_message_word(mword), .msg_ready(mready));
  uirq_engine_model u_eng (.clk(clk), .srst(srst), .irq_out(irq), .ack_wait(ack_wait), .send(send),
    .send_word(sword), .msg_ready(mready), .irq_ack(ack), .msg_valid(mvalid), .received_message_word(mword));
  task complete_run;
    $display("Checks %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Register write: strobe for one edge
  task wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask
  // Register read and compare; answer one cycle after the strobe
  task rdc(input logic [11:0] a, input logic [31:0] exp);
    @(posedge clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: '0};
    @(posedge clk);
    req.rd <= 1'b0;
    #1;
    chk(32'(rvalid), 32'h0000_0001);
    chk(rdata, exp);
  endtask
  task wait_irq(input logic lvl);
    for (int k = 0; k < 30 && irq.valid !== lvl; k++) @(posedge clk) #1;
    chk(32'(irq.valid), 32'(lvl));
  endtask
  initial begin
    repeat (3000) @(posedge clk);
    miscompares++;
    complete_run;
  end
  initial begin
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    wr(12'h00a8, 32'hffff_ffff);
    foreach (offs[k]) rdc(offs[k], 32'h0000_0000);
    wr(UIRQ_OFS_MASK, 32'hffff_ffff);
    rdc(UIRQ_OFS_MASK, 32'hffff_ffff);
    wr(UIRQ_OFS_REQUEST, 32'hffff_fffe);
    rdc(UIRQ_OFS_REQUEST, 32'h000f_f1f0);
    chk(32'(irq.valid), 32'h0000_0000);
    // Direct trigger with a slow acknowledge
    ack_wait <= 4'h6;
    wr(UIRQ_OFS_REQUEST, 32'h0001_2031);
    #1;
    chk(32'(irq), 32'({1'b1, 8'h12, 5'h03}));
    rdc(UIRQ_OFS_REQUEST, 32'h0001_2031);
    // Fields stay frozen while the request is outstanding
    wr(UIRQ_OFS_REQUEST, 32'h000a_b0f0);
    #1;
    chk(32'(irq), 32'({1'b1, 8'h12, 5'h03}));
    wait_irq(1'b0);
    rdc(UIRQ_OFS_REQUEST, 32'h0001_2030);
    // Aggregation under the mask, prompt acknowledge
    ack_wait <= 4'h0;
    wr(UIRQ_OFS_MASK, 32'h0000_0010);
    wr(UIRQ_OFS_PENDING, 32'h0000_0001);
    repeat (2) @(posedge clk) #1;
    chk(32'(irq.valid), 32'h0000_0000);
    wr(UIRQ_OFS_PENDING, 32'h0000_0011);
    wait_irq(1'b1);
    chk(32'({irq.func, irq.vec}), 32'({8'h12, 5'h03}));
    rdc(UIRQ_OFS_PENDING, 32'h0000_0011);
    rdc(UIRQ_OFS_PENDING, 32'h0000_0000);
    repeat (4) @(posedge clk) #1;
    chk(32'(irq.valid), 32'h0000_0000);
    // Soft reset pulse length
    wr(UIRQ_OFS_SRST, 32'h0000_0001);
    i = 0;
    repeat (2 * UIRQ_SRST_CYCLES) begin
      #1;
      if (n_rst === 1'b1) break;
      i++;
      @(posedge clk);
    end
    chk(32'(i), 32'(UIRQ_SRST_CYCLES));
    rdc(UIRQ_OFS_SRST, 32'h0000_0000);
    // Message words in, popped oldest first
    for (i = 0; i < 3; i++) begin
      @(posedge clk);
      send <= 1'b1;
      sword <= 32'hc0de_0000 + 32'(i);
      @(posedge clk);
      send <= 1'b0;
      repeat (4) @(posedge clk);
    end
    for (i = 0; i < 3; i++) rdc(UIRQ_OFS_MSG, 32'hc0de_0000 + 32'(i));
    rdc(UIRQ_OFS_MSG, 32'h0000_0000);
    complete_run;
  end
endmodule // uirq_regs_tb
bind uirq_regs uirq_regs_chk #(.SRST_CYCLES(SRST_CYCLES)) u_chk (.clk(clk), .srst(srst), .reg_req(reg_req),
  .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .irq_out(irq_out), .irq_ack(irq_ack),
  .engine_soft_reset_n(engine_soft_reset_n), .msg_valid(msg_valid), .received_message_word(received_message_word),
  .msg_ready(msg_ready));
